// >>> rtl/spi_eeprom_map.svh
`ifndef SPI_EEPROM_MAP_SVH
`define SPI_EEPROM_MAP_SVH

// ****************************************
// Serial framing
// ****************************************
`define BYTE_W      8
`define BIT_CNT_W   3
`define BIT_ZERO    3'h0
`define BIT_ONE     3'h1
`define BIT_LAST    3'h7

// ****************************************
// Array and status layout
// ****************************************
`define MEM_DEPTH   512
`define ADDR_W      9
`define SR_NV_W     3
`define SR_SWD_BIT  2
`define SR_BPH_BIT  1
`define SR_BPL_BIT  0
`define WEL_RST     1'h0
`define NV_RST      3'h0

// ****************************************
// Write cycle timing and crossings
// ****************************************
`define CNT_W       16
`define CNT_ZERO    16'h0000
`define CNT_ONE     16'h0001
`define SYNC_W      3
`define SYNC_CS     0
`define SYNC_WP     1
`define SYNC_TOG    2

`endif

// >>> rtl/spi_eeprom_pkg.sv
`include "spi_eeprom_map.svh"

package spi_eeprom_pkg;

    typedef enum logic {
        WR_IDLE,
        WR_BUSY
    } wr_state_e;

    typedef struct packed {
        logic status_write_disable;
        logic block_protect_hi;
        logic block_protect_lo;
        logic write_enable_latch;
        logic write_in_progress;
    } status_s;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`BYTE_W-1:0] data;
    } mem_req_s;

endpackage : spi_eeprom_pkg

// >>> rtl/bit_sync.sv
`timescale 1ns/10ps
`include "spi_eeprom_map.svh"

// ****************************************
// Two-stage level synchroniser
// ****************************************
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else if (ce)
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : bit_sync

// >>> rtl/spi_eeprom_front.sv
`timescale 1ns/10ps
`include "spi_eeprom_map.svh"

// Notes on behaviour
// RL1: Serial output bit changes on each falling serial clock edge.
// RL2: Input bits are captured on rising serial clock edges; master sets them up first.
// RL3: Chip select high deselects and floats the serial output.
// RL4: Deselected falls to standby unless a write cycle runs; selected is active.
// RL5: After reset, selection needs a falling chip select edge; high must come first.
// RL6: During a pause output floats and serial clock and input are ignored.
// RL7: Pause can only start while selected; master keeps select low.
// RL8: Pause keeps selection; the byte sequence resumes where it stopped.
// RL9: Write protect low refuses memory writes; other operations keep working.
// RL10: Reset ignores all requests; afterwards deselected and in standby.
// RL11: Reset clears write enable latch and write in progress.
// RL12: Reset leaves the non-volatile status bits unchanged.
// RL13: Array holds 512 bytes of 8 bits.
// RL14: Master deselects and waits out write cycles before supply removal.
// RL15: Pause starts or ends on hold edges while serial clock is low.
// RL16: Chip select high during a pause resets the interface state.
// RL17: All bytes move most significant bit first.
// RL18: Master uses clock idle low or idle high; sample rising, drive falling.
// RL19: Reset input forces volatile status and deselected interface state.
// RL20: Chip select and hold changes outside entry conditions are ignored.

module spi_eeprom_front
    import spi_eeprom_pkg::*;
#(
    parameter logic [`CNT_W-1:0] WRITE_CYCLES = 16'h03e8
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    // Serial pins
    input  wire logic                sclk,
    input  wire logic                mosi,
    input  wire logic                cs_n,
    input  wire logic                hold_n,
    input  wire logic                wp_n,
    output logic                     miso_o,
    output logic                     miso_oe,
    // Byte stream
    output logic                     rx_valid,
    output logic [`BYTE_W-1:0]       rx_data,
    input  wire logic                tx_load,
    input  wire logic [`BYTE_W-1:0]  tx_data,
    // Status control
    input  wire logic                wel_set,
    input  wire logic                wel_clr,
    input  wire logic                sr_wr,
    input  wire logic [`SR_NV_W-1:0] sr_data,
    input  wire logic [`SR_NV_W-1:0] nv_init,
    output status_s                  status,
    // Array access
    input  wire logic                mem_wr,
    input  wire logic                mem_rd,
    input  wire mem_req_s            mem_req,
    output logic                     rd_valid,
    output logic [`BYTE_W-1:0]       rd_data,
    output logic                     wr_refused,
    // Power state
    output logic                     selected,
    output logic                     standby
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [`BYTE_W-1:0]    shift_in_q;
    logic [`BIT_CNT_W-1:0] bit_cnt_q;
    logic [`BYTE_W-1:0]    rx_word_q;
    logic                  rx_tog_q;
    logic [`BYTE_W-1:0]    tx_sh_q;
    logic                  miso_q;
    logic                  paused_q;
    logic [`BYTE_W-1:0]    tx_word_q;
    logic                  armed_q;
    logic                  rx_seen_q;
    logic                  rx_valid_q;
    logic [`BYTE_W-1:0]    rx_data_q;
    logic                  nv_loaded_q;
    logic [`SR_NV_W-1:0]   nv_q;
    logic                  wel_q;
    wr_state_e             state_q;
    wr_state_e             state_d;
    logic [`CNT_W-1:0]     cnt_q;
    logic                  rd_valid_q;
    logic [`BYTE_W-1:0]    rd_data_q;
    logic                  refused_q;
    logic [`BYTE_W-1:0]    mem [`MEM_DEPTH];
    logic [`SYNC_W-1:0]    sync_d;
    logic [`SYNC_W-1:0]    sync_q;

    // ****************************************
    // Link side decode
    // ****************************************
    // The link is held in reset whenever deselected or not yet armed, so a
    // chip select rise in a pause throws away the partial byte. [RL16] [RL20]
    wire link_rst   = rst | cs_n | ~armed_q;                          // [RL3] [RL19]
    wire byte_done  = bit_cnt_q == `BIT_LAST;
    wire [`BYTE_W-1:0] shift_in_d = {shift_in_q[`BYTE_W-2:0], mosi}; // [RL17]
    // Pause follows hold only while the clock is low; a hold edge in the
    // high phase is taken at the next falling edge. [RL15]
    wire hold_eff   = sclk ? paused_q : ~hold_n;
    wire take_bit   = hold_n;                                         // [RL6]

    // ****************************************
    // Link capture, rising edge
    // ****************************************
    always_ff @(posedge sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            shift_in_q <= '0;
            bit_cnt_q  <= `BIT_ZERO;
        end
        else if (take_bit)                                            // [RL6] [RL8]
        begin
            shift_in_q <= shift_in_d;                                 // [RL2]
            bit_cnt_q  <= bit_cnt_q + `BIT_ONE;
        end
    end

    // The word and its toggle survive deselection so the core never sees a
    // false byte event when chip select rises.
    always_ff @(posedge sclk or posedge rst)
    begin
        if (rst)
        begin
            rx_word_q <= '0;
            rx_tog_q  <= 1'h0;
        end
        else if (!link_rst && take_bit && byte_done)
        begin
            rx_word_q <= shift_in_d;                                  // [RL2]
            rx_tog_q  <= ~rx_tog_q;
        end
    end

    // ****************************************
    // Link output, falling edge
    // ****************************************
    always_ff @(negedge sclk or posedge link_rst)
    begin
        if (link_rst)
        begin
            paused_q <= 1'h0;
            miso_q   <= 1'h0;
            tx_sh_q  <= '0;
        end
        else
        begin
            paused_q <= ~hold_n;                                      // [RL7] [RL15]
            if (hold_n)
            begin
                if (bit_cnt_q == `BIT_ZERO)
                begin
                    miso_q  <= tx_word_q[`BYTE_W-1];                  // [RL1] [RL17]
                    tx_sh_q <= {tx_word_q[`BYTE_W-2:0], 1'h0};
                end
                else
                begin
                    miso_q  <= tx_sh_q[`BYTE_W-1];                    // [RL1]
                    tx_sh_q <= {tx_sh_q[`BYTE_W-2:0], 1'h0};
                end
            end
        end
    end

    assign miso_o  = miso_q;
    assign miso_oe = ~link_rst & ~hold_eff;                           // [RL3] [RL6]

    // ****************************************
    // Crossings into the core
    // ****************************************
    assign sync_d[`SYNC_CS]  = cs_n;
    assign sync_d[`SYNC_WP]  = wp_n;
    assign sync_d[`SYNC_TOG] = rx_tog_q;

    bit_sync #(
        .W (`SYNC_W)
    ) u_sync (
        .clk (ref_clk),
        .rst (rst),
        .ce  (ce),
        .d   (sync_d),
        .q   (sync_q)
    );

    wire cs_s     = sync_q[`SYNC_CS];
    wire wp_s     = sync_q[`SYNC_WP];
    wire rx_event = sync_q[`SYNC_TOG] ^ rx_seen_q;

    // ****************************************
    // Selection and arming
    // ****************************************
    // Armed only after chip select is seen high, so a pin already low at
    // reset release never selects. armed_q only rises while cs_n is high,
    // which keeps the link in reset over that change.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            armed_q <= 1'h0;                                          // [RL10]
        else if (ce && cs_s)
            armed_q <= 1'h1;                                          // [RL5]
    end

    assign selected = armed_q & ~cs_s;                                // [RL4]
    assign standby  = ~selected & (state_q == WR_IDLE);               // [RL4] [RL10]

    // ****************************************
    // Byte stream to and from the user side
    // ****************************************
    // Bytes cross by toggle; the master must leave at least four core cycles
    // between byte ends, since there is no buffering here.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_seen_q  <= 1'h0;
            rx_valid_q <= 1'h0;
            rx_data_q  <= '0;
            tx_word_q  <= '0;
        end
        else if (ce)
        begin
            rx_seen_q  <= sync_q[`SYNC_TOG];
            rx_valid_q <= rx_event;
            if (rx_event)
                rx_data_q <= rx_word_q;
            if (tx_load)
                tx_word_q <= tx_data;
        end
    end

    assign rx_valid = rx_valid_q;
    assign rx_data  = rx_data_q;

    // ****************************************
    // Status and write cycle
    // ****************************************
    wire wr_ok    = wel_q & (state_q == WR_IDLE);
    wire mem_go   = ce & mem_wr & wr_ok & wp_s;                       // [RL9]
    wire sr_go    = ce & sr_wr & wr_ok & ~mem_wr;
    wire wr_start = mem_go | sr_go;
    wire cnt_end  = cnt_q == `CNT_ZERO;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            WR_IDLE:
                if (wr_start)
                    state_d = WR_BUSY;
            WR_BUSY:
                if (cnt_end)
                    state_d = WR_IDLE;
            default:
                state_d = WR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= WR_IDLE;                                       // [RL11]
            cnt_q   <= `CNT_ZERO;
        end
        else if (ce)
        begin
            state_q <= state_d;
            if (wr_start)
                cnt_q <= WRITE_CYCLES - `CNT_ONE;
            else if (!cnt_end)
                cnt_q <= cnt_q - `CNT_ONE;
        end
    end

    // A completed write start drops the latch; a set in that cycle wins.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wel_q <= `WEL_RST;                                        // [RL11]
        else if (ce)
        begin
            if (wel_set)
                wel_q <= 1'h1;
            else if (wel_clr || wr_start)
                wel_q <= 1'h0;
        end
    end

    // Non-volatile bits are reloaded from their stored image after reset.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            nv_loaded_q <= 1'h0;
            nv_q        <= `NV_RST;
        end
        else if (ce)
        begin
            nv_loaded_q <= 1'h1;
            if (!nv_loaded_q)
                nv_q <= nv_init;                                      // [RL12]
            else if (sr_go)
                nv_q <= sr_data;
        end
    end

    assign status.status_write_disable = nv_q[`SR_SWD_BIT];
    assign status.block_protect_hi     = nv_q[`SR_BPH_BIT];
    assign status.block_protect_lo     = nv_q[`SR_BPL_BIT];
    assign status.write_enable_latch   = wel_q;
    assign status.write_in_progress    = state_q == WR_BUSY;

    // ****************************************
    // Array
    // ****************************************
    always_ff @(posedge ref_clk)
    begin
        if (mem_go)
            mem[mem_req.addr] <= mem_req.data;                        // [RL13]
    end

    // Reads are ignored while a write cycle runs.
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_valid_q <= 1'h0;
            rd_data_q  <= '0;
            refused_q  <= 1'h0;
        end
        else if (ce)
        begin
            rd_valid_q <= mem_rd & (state_q == WR_IDLE);
            if (mem_rd && state_q == WR_IDLE)
                rd_data_q <= mem[mem_req.addr];
            refused_q <= mem_wr & ~mem_go;                            // [RL9]
        end
    end

    assign rd_valid   = rd_valid_q;
    assign rd_data    = rd_data_q;
    assign wr_refused = refused_q;

    // ****************************************
    // Checks
    // ****************************************
    reset_clears_a : assert property (@(posedge ref_clk) // [RL11]
        $past(rst) |-> (!wel_q && state_q == WR_IDLE))
        else $error("volatile status not cleared by reset");

    wp_refuse_a : assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
        (ce && mem_wr && !wp_s && !sr_wr) |=> (wr_refused && !$rose(status.write_in_progress)))
        else $error("write accepted while protected");

    write_start_a : assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
        (ce && mem_wr && !wel_set && wp_s && wel_q && state_q == WR_IDLE)
        |=> (status.write_in_progress && !wel_q) [*2])
        else $error("accepted write did not start a cycle");

    busy_active_a : assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
        status.write_in_progress |-> !standby)
        else $error("standby during write cycle");

    arm_first_a : assert property (@(posedge ref_clk) disable iff (rst) // [RL5]
        (!armed_q && !cs_s) |-> (!selected && !miso_oe))
        else $error("selected before first chip select high");

    rx_pulse_a : assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
        (rx_valid && ce) |=> (!rx_valid && rx_data == $past(rx_word_q, 2)))
        else $error("byte event not a single pulse");

    nv_keep_a : assert property (@(posedge ref_clk) disable iff (rst) // [RL12]
        (nv_loaded_q && ce && !sr_go) |=> $stable(nv_q))
        else $error("non-volatile bits changed without status write");

    pause_float_a : assert property (@(negedge sclk) disable iff (link_rst) // [RL6]
        !hold_n |=> (!miso_oe && $stable(miso_q)))
        else $error("output driven during pause");

    pause_count_a : assert property (@(posedge sclk) disable iff (link_rst) // [RL8]
        !hold_n |=> $stable(bit_cnt_q))
        else $error("bit count moved during pause");

endmodule : spi_eeprom_front

// >>> verification/spi_master_model.sv
`timescale 1ns/10ps

// ****************************************
// Serial bus master, link half period 7.5 ns
// ****************************************
module spi_master_model (
    output logic      sclk,
    output logic      mosi,
    output logic      cs_n,
    output logic      hold_n,
    input  wire logic miso_o,
    input  wire logic miso_oe
);
    logic mode3;
    logic last_q;
    // A released line shows the inverse of its last value, never a stale copy
    wire  miso_line = miso_oe ? miso_o : ~last_q;

    always @(posedge sclk)
    begin
        if (miso_oe)
        begin
            last_q <= miso_o;
        end
    end

    initial
    begin
        mode3  = 1'b0;
        sclk   = 1'b0;
        mosi   = 1'b0;
        cs_n   = 1'b0;
        hold_n = 1'b1;
        last_q = 1'b0;
    end

    // Clock parks at its idle level before select falls
    task automatic select(input logic m3);
        mode3 = m3;
        sclk  = m3;
        #20 cs_n = 1'b0;
        #20;
    endtask : select

    task automatic deselect;
        #20 cs_n = 1'b1;
        #300;
    endtask : deselect

    // Drive on the fall, sample on the rise, top bit first
    task automatic shift(input logic [7:0] b, input int n, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < n; i++)
        begin
            if (mode3) sclk = 1'b0;
            mosi = b[7-i];
            #7.5 sclk = 1'b1;
            r[7-i] = miso_line;
            #7.5;
            if (!mode3) sclk = 1'b0;
        end
    endtask : shift

    // Hold edges only while the clock is low; select may be low or already high
    task automatic pause(input logic h);
        #10 hold_n = h;
        #10;
    endtask : pause

    task automatic junk_clocks;
        for (int i = 0; i < 3; i++)
        begin
            mosi = ~mosi;
            #7.5 sclk = 1'b1;
            #7.5 sclk = 1'b0;
        end
    endtask : junk_clocks
endmodule : spi_master_model

// >>> verification/spi_eeprom_pin_front_end_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end

// ****************************************
// Bench top
// ****************************************
module spi_eeprom_pin_front_end_tb_top
    import spi_eeprom_pkg::*;
;
    logic ref_clk, rst, sclk, mosi, cs_n, hold_n, wp_n, miso_o, miso_oe;
    logic rx_valid, tx_load, wel_set, wel_clr, sr_wr, mem_wr, mem_rd;
    logic rd_valid, wr_refused, selected, standby, ce;
    logic [7:0] rx_data, tx_data, rd_data, r;
    logic [2:0] sr_data, nv_init;
    status_s    status;
    mem_req_s   mem_req;
    int         mismatches = 0;
    int         n_tests = 0;
    wire  [2:0] nv = {status.status_write_disable, status.block_protect_hi,
                      status.block_protect_lo};

    spi_eeprom_front #(.WRITE_CYCLES(16'h0008)) i_spi_eeprom_front (
        .ref_clk(ref_clk), .rst(rst), .ce(ce), .sclk(sclk), .mosi(mosi), .cs_n(cs_n),
        .hold_n(hold_n), .wp_n(wp_n), .miso_o(miso_o), .miso_oe(miso_oe),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_load(tx_load), .tx_data(tx_data),
        .wel_set(wel_set), .wel_clr(wel_clr), .sr_wr(sr_wr), .sr_data(sr_data),
        .nv_init(nv_init), .status(status), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_req(mem_req), .rd_valid(rd_valid), .rd_data(rd_data),
        .wr_refused(wr_refused), .selected(selected), .standby(standby));

    spi_master_model i_spi_master_model (
        .sclk(sclk), .mosi(mosi), .cs_n(cs_n), .hold_n(hold_n),
        .miso_o(miso_o), .miso_oe(miso_oe));

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task report_and_stop;
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // Pulses the core requests {wel_set, wel_clr, mem_wr, mem_rd, sr_wr}
    task automatic core(input logic [4:0] p);
        @(posedge ref_clk) {wel_set, wel_clr, mem_wr, mem_rd, sr_wr} <= p;
        @(posedge ref_clk) {wel_set, wel_clr, mem_wr, mem_rd, sr_wr} <= 5'h00;
        #1;
    endtask : core

    // Bounded wait; extra gap keeps bytes apart since there is no buffer
    task automatic wait_rx(input logic [7:0] ex);
        int i;
        i = 0;
        while (rx_valid !== 1'b1 && i < 20)
        begin
            @(posedge ref_clk) #1 i++;
        end
        `CHK("rx_valid", 1'b1, rx_valid)
        `CHK("rx_data", ex, rx_data)
        repeat (2) @(posedge ref_clk);
    endtask : wait_rx

    task automatic t_reset;
        repeat (3) @(posedge ref_clk);
        #1 `CHK("selected", 1'b0, selected)
        `CHK("standby", 1'b1, standby)
        `CHK("miso_oe", 1'b0, miso_oe)
        `CHK("wel_wip", 2'b00, {status.write_enable_latch, status.write_in_progress})
        `CHK("nv", 3'h6, nv)
        i_spi_master_model.deselect();
    endtask : t_reset

    task automatic t_mode0;
        @(posedge ref_clk) {tx_load, tx_data} <= {1'b1, 8'h3c};
        @(posedge ref_clk) tx_load <= 1'b0;
        i_spi_master_model.select(1'b0);
        i_spi_master_model.shift(8'ha5, 8, r);
        `CHK("miso0", 8'h00, r)
        wait_rx(8'ha5);
        `CHK("selected", 1'b1, selected)
        `CHK("standby", 1'b0, standby)
        i_spi_master_model.shift(8'h5a, 8, r);
        `CHK("miso1", 8'h3c, r)
        wait_rx(8'h5a);
        i_spi_master_model.deselect();
        `CHK("miso_oe", 1'b0, miso_oe)
        `CHK("idle", 2'b01, {selected, standby})
    endtask : t_mode0

    task automatic t_mode3;
        @(posedge ref_clk) {tx_load, tx_data} <= {1'b1, 8'hc3};
        @(posedge ref_clk) tx_load <= 1'b0;
        i_spi_master_model.select(1'b1);
        i_spi_master_model.shift(8'h96, 8, r);
        `CHK("miso3", 8'hc3, r)
        wait_rx(8'h96);
        i_spi_master_model.deselect();
    endtask : t_mode3

    task automatic t_pause;
        i_spi_master_model.select(1'b0);
        i_spi_master_model.shift(8'hb4, 4, r);
        i_spi_master_model.pause(1'b0);
        `CHK("miso_oe", 1'b0, miso_oe)
        i_spi_master_model.junk_clocks();
        repeat (4) @(posedge ref_clk);
        #1 `CHK("selected", 1'b1, selected)
        i_spi_master_model.pause(1'b1);
        i_spi_master_model.shift(8'h40, 4, r);
        wait_rx(8'hb4);
        i_spi_master_model.shift(8'hff, 3, r);
        i_spi_master_model.pause(1'b0);
        i_spi_master_model.deselect();
        i_spi_master_model.pause(1'b1);
        i_spi_master_model.select(1'b0);
        i_spi_master_model.shift(8'h81, 8, r);
        wait_rx(8'h81);
        i_spi_master_model.deselect();
    endtask : t_pause

    task automatic t_write;
        int i;
        @(posedge ref_clk) ce <= 1'b0;
        core(5'h10);
        `CHK("frozen", 1'b0, status.write_enable_latch)
        @(posedge ref_clk) ce <= 1'b1;
        core(5'h10);
        core(5'h08);
        `CHK("wel_clr", 1'b0, status.write_enable_latch)
        @(posedge ref_clk) mem_req <= {9'h1ff, 8'h5a};
        core(5'h10);
        core(5'h04);
        `CHK("wip", 2'b10, {status.write_in_progress, status.write_enable_latch})
        `CHK("standby", 1'b0, standby)
        i = 0;
        while (status.write_in_progress !== 1'b0 && i < 20)
        begin
            @(posedge ref_clk) #1 i++;
        end
        `CHK("wip_len", 1'b1, (i >= 6 && i <= 9))
        core(5'h02);
        `CHK("rd", 9'h15a, {rd_valid, rd_data})
        @(posedge ref_clk) {wp_n, mem_req} <= {1'b0, 9'h1ff, 8'ha0};
        repeat (4) @(posedge ref_clk);
        core(5'h10);
        core(5'h04);
        `CHK("refused", 2'b10, {wr_refused, status.write_in_progress})
        core(5'h02);
        `CHK("rd_kept", 8'h5a, rd_data)
        @(posedge ref_clk) sr_data <= 3'h5;
        core(5'h01);
        `CHK("nv", 3'h5, nv)
        @(posedge ref_clk) {wp_n, nv_init} <= {1'b1, 3'h5};
        repeat (4) @(posedge ref_clk);
        core(5'h10);
        core(5'h04);
        @(posedge ref_clk) rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 `CHK("rst_wip", 2'b00, {status.write_in_progress, status.write_enable_latch})
        @(posedge ref_clk) rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 `CHK("rst_nv", 3'h5, nv)
        `CHK("rst_idle", 2'b01, {selected, standby})
    endtask : t_write

    initial
    begin
        {rst, wp_n, nv_init, sr_data} = {1'b1, 1'b1, 3'h6, 3'h0};
        ce = 1'b1;
        {tx_load, tx_data, wel_set, wel_clr, sr_wr, mem_wr, mem_rd} = 13'h0000;
        mem_req = 17'h0_0000;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_mode0();
        t_mode3();
        t_pause();
        t_write();
        report_and_stop();
    end

    initial
    begin
        #2000000 mismatches++;
        report_and_stop();
    end
endmodule : spi_eeprom_pin_front_end_tb_top
